// *** include/sadc_pkg.sv ***
// Shared constants, types and register layout of the converter sequencer.
package sadc_pkg;

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the bus.
localparam logic [7:0] OFF_CTRL1 = 8'h00;
localparam logic [7:0] OFF_CTRL2 = 8'h04;
localparam logic [7:0] OFF_CTRL3 = 8'h08;
localparam logic [7:0] OFF_INSEL = 8'h0C;
localparam logic [7:0] OFF_SCAN  = 8'h10;
localparam logic [7:0] OFF_STAT  = 8'h14;
localparam logic [1:0] RES_PAGE  = 2'h1;   // Results at 0x40..0x7C.

// Field positions.
localparam int unsigned B_ON    = 15;
localparam int unsigned B_OUTPUT_FORMAT_SEL  = 8;
localparam int unsigned B_TRIGGER_SOURCE_SEL  = 5;
localparam int unsigned B_AUTO_SAMPLE_ENABLE  = 2;
localparam int unsigned B_SAMPLE_HOLD_CMD  = 1;
localparam int unsigned B_DONE  = 0;
localparam int unsigned B_SCAN_MUX_A_ENABLE = 10;
localparam int unsigned B_HALF  = 7;
localparam int unsigned B_SAMPLES_PER_IRQ  = 2;
localparam int unsigned B_SPLIT_BUFFER_MODE  = 1;
localparam int unsigned B_ALTERNATE_MUX_SELECT  = 0;
localparam int unsigned B_AUTO_SAMPLE_CLOCKS  = 8;
localparam int unsigned B_RC_CLOCK_SELECT  = 7;
localparam int unsigned B_CONV_CLOCK_DIVIDER  = 0;
localparam int unsigned B_CHA   = 0;
localparam int unsigned B_CHB   = 8;
localparam int unsigned B_IRQ   = 0;

////////////////////////////////////////////////////////////////////////////////
// Timing, trigger and format codes.
localparam logic [4:0] CONV_LAST = 5'h0D;  // Fourteen periods: counts 0 to 13.
localparam logic [3:0] NUM_PINS  = 4'hD;   // Inputs 13 to 15 have no pin.
localparam logic [2:0] TRIG_MANUAL = 3'h0;
localparam logic [2:0] TRIG_EXT    = 3'h1;
localparam logic [2:0] TRIG_TIMER  = 3'h2;
localparam logic [2:0] TRIG_AUTO   = 3'h7;
localparam logic [1:0] FMT_INT   = 2'h0;
localparam logic [1:0] FMT_SINT  = 2'h1;
localparam logic [1:0] FMT_FRAC  = 2'h2;
localparam logic [1:0] FMT_SFRAC = 2'h3;

typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV   = 3'b100
} sadc_state_t;

typedef struct packed {
    logic        converter_on;
    logic [1:0]  output_format_sel;
    logic [2:0]  trigger_source_sel;
    logic        auto_sample_enable;
    logic        sample_hold_cmd;
    logic        done;
    logic        scan_mux_a_enable;
    logic [3:0]  samples_per_irq;
    logic        split_buffer_mode;
    logic        alternate_mux_select;
    logic [4:0]  auto_sample_clocks;
    logic        rc_clock_select;
    logic [5:0]  conv_clock_divider;
    logic [3:0]  mux_a_channel;
    logic [3:0]  mux_b_channel;
    logic [15:0] scan_select;
    logic        conv_irq_flag;
} sadc_cfg_t;

localparam sadc_cfg_t CFG_RST = '0;

typedef struct packed {
    logic        en;
    logic [3:0]  addr;
    logic [11:0] data;
} sadc_wr_t;

typedef struct packed {
    logic       rc_s1;
    logic       rc_s2;
    logic       rc_s3;
    logic [5:0] cnt;
    logic       tick;
} sadc_div_t;

endpackage

// *** hw/sadc_clkdiv.sv ***
// Conversion clock period generator: divided system clock or synchronised RC clock.
`timescale 1ns/1ps
module sadc_clkdiv #(
    parameter int unsigned DIVW = 6
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            run_i,
    input  wire logic [DIVW-1:0] div_i,
    input  wire logic            rc_sel_i,
    input  wire logic            rc_clk_i,
    output logic                 tick_o
);
    if (DIVW != 6) $error("sadc_clkdiv: divider field must be six bits");

    sadc_pkg::sadc_div_t r;
    sadc_pkg::sadc_div_t n;

    // One system clock is half an instruction cycle, so the period is divider+1 clocks.
    always_comb begin
        n       = r;
        n.rc_s1 = rc_clk_i;
        n.rc_s2 = r.rc_s1;
        n.rc_s3 = r.rc_s2;
        n.tick  = 1'b0;
        if (!run_i) begin
            n.cnt = '0;
        end else if (rc_sel_i) begin
            n.cnt  = '0;
            n.tick = r.rc_s2 & ~r.rc_s3;
        end else if (r.cnt == div_i) begin
            n.cnt  = '0;
            n.tick = 1'b1;
        end else begin
            n.cnt = r.cnt + 6'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick_o = r.tick;
endmodule // sadc_clkdiv

// *** hw/sadc_result_store.sv ***
// Sixteen-word, twelve-bit result store with a formatted read port.
`timescale 1ns/1ps
module sadc_result_store #(
    parameter int unsigned DEPTH = 16,
    parameter int unsigned W     = 12
) (
    input  wire logic              clk_i,
    input  wire sadc_pkg::sadc_wr_t wr_i,
    input  wire logic [3:0]        rd_addr_i,
    input  wire logic [1:0]        output_format_sel_i,
    output logic [15:0]            rd_data_o
);
    if (DEPTH != 16 || W != 12) $error("sadc_result_store: only 16 x 12 is served");

    logic [W-1:0] mem [DEPTH];

    // Results are kept unformatted, so the read format may change at any time.
    function automatic logic [15:0] fmt(input logic [11:0] d, input logic [1:0] f);
        case (f)
            sadc_pkg::FMT_INT:  fmt = {4'h0, d};
            sadc_pkg::FMT_SINT: fmt = {{4{d[11]}}, d};
            default:            fmt = {d, 4'h0};
        endcase
    endfunction

    // Only the sequencer writes; no bus path reaches this port.
    always_ff @(posedge clk_i) begin
        if (wr_i.en) begin
            mem[wr_i.addr] <= wr_i.data;
        end
    end

    assign rd_data_o = fmt(mem[rd_addr_i], output_format_sel_i);
endmodule // sadc_result_store

// *** hw/sadc_top.sv ***
// Sequencer and Wishbone register file of the twelve-bit SAR converter.
// Operation
// - Sixteen twelve-bit result words, software cannot write.
// - Results read as sixteen bits, four codes, three formats.
// - Setting sample command starts acquisition.
// - Store each result; flag after chosen sample count.
// - Samples-per-interrupt field sets one to sixteen.
// - Split mode fills halves alternately per interrupt.
// - Alternate clear: every sample from group A.
// - Alternate set: groups A and B alternate.
// - Scan steps group A over selected inputs.
// - Scan ascends, restarts per interrupt, excess unused.
// - Inputs 13 to 15 convert as zero.
// - Manual trigger: clearing sample command converts.
// - Auto trigger: convert after sample clock count.
// - Triggers 1 and 2: external event or timer; codes 3 to 6 never convert.
// - Turning off aborts conversion, halts sequencing.
// - Aborted conversion leaves result store unchanged.
// - Turning off beats a same-cycle auto start.
// - A conversion takes fourteen conversion periods.
// - Period is half-cycles times divider plus one.
// - RC select clocks converter from RC oscillator.
// - Off means sequencer logic idle and disabled.
// - Format selects read view; stored data right-justified.
`timescale 1ns/1ps
module sadc_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    input  wire logic        rc_clk_i,
    input  wire logic        ext_trig_i,
    input  wire logic        timer_trig_i,
    input  wire logic [11:0] sar_data_i,
    output logic             sample_o,
    output logic [3:0]       channel_o,
    output logic             convert_o,
    output logic             done_o
);
    typedef struct packed {
        sadc_pkg::sadc_cfg_t   cfg;
        sadc_pkg::sadc_state_t st;
        logic [4:0]            cnt;
        logic [3:0]            smp_cnt;
        logic [4:0]            scan_idx;
        logic                  alt_phase;
        logic                  half;
        logic [3:0]            ch;
        logic                  ext_s1;
        logic                  ext_s2;
        logic                  ext_s3;
        logic                  ack;
        logic [15:0]           dat;
        logic                  sampling;
        logic                  converting;
        sadc_pkg::sadc_wr_t    wr;
    } sadc_top_t;

    sadc_top_t   r;
    sadc_top_t   n;
    logic        tick;
    logic [15:0] res_rd;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  sel);
        merge16[7:0]  = sel[0] ? new_v[7:0] : old_v[7:0];
        merge16[15:8] = sel[1] ? new_v[15:8] : old_v[15:8];
    endfunction

    // Lowest selected input at or above the start; wraps if the tail is empty.
    function automatic logic [3:0] scan_pick(input logic [15:0] m,
                                             input logic [4:0]  from,
                                             input logic [3:0]  dflt);
        logic found;
        found     = 1'b0;
        scan_pick = dflt;
        for (int i = 15; i >= 0; i--) begin
            if (m[i] && i >= int'(from)) begin
                scan_pick = 4'(i);
                found     = 1'b1;
            end
        end
        if (!found) begin
            for (int i = 15; i >= 0; i--) begin
                if (m[i]) begin
                    scan_pick = 4'(i);
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Submodules.
    sadc_clkdiv #(.DIVW(6)) u_div (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .run_i    (r.cfg.converter_on),
        .div_i    (r.cfg.conv_clock_divider),
        .rc_sel_i (r.cfg.rc_clock_select),
        .rc_clk_i (rc_clk_i),
        .tick_o   (tick)
    );

    sadc_result_store #(.DEPTH(16), .W(12)) u_store (
        .clk_i     (clk_i),
        .wr_i      (r.wr),
        .rd_addr_i (adr_i[5:2]),
        .output_format_sel_i    (r.cfg.output_format_sel),
        .rd_data_o (res_rd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        logic [15:0] c1;
        logic [15:0] c2;
        logic [15:0] c3;
        logic [15:0] ins;
        logic [15:0] v;
        logic        req;
        logic        ext_edge;
        logic        go;
        logic        start;
        logic [3:0]  pick;
        c1       = '0;
        c2       = '0;
        c3       = '0;
        ins      = '0;
        v        = '0;
        go       = 1'b0;
        start    = 1'b0;
        pick     = '0;
        n        = r;
        n.ack    = 1'b0;
        n.wr     = '0;
        n.ext_s1 = ext_trig_i;
        n.ext_s2 = r.ext_s1;
        n.ext_s3 = r.ext_s2;
        ext_edge = r.ext_s2 & ~r.ext_s3;
        req      = cyc_i & stb_i & ~r.ack;

        c1[sadc_pkg::B_ON]        = r.cfg.converter_on;
        c1[sadc_pkg::B_OUTPUT_FORMAT_SEL+:2]   = r.cfg.output_format_sel;
        c1[sadc_pkg::B_TRIGGER_SOURCE_SEL+:3]   = r.cfg.trigger_source_sel;
        c1[sadc_pkg::B_AUTO_SAMPLE_ENABLE]      = r.cfg.auto_sample_enable;
        c1[sadc_pkg::B_SAMPLE_HOLD_CMD]      = r.cfg.sample_hold_cmd;
        c1[sadc_pkg::B_DONE]      = r.cfg.done;
        c2[sadc_pkg::B_SCAN_MUX_A_ENABLE]     = r.cfg.scan_mux_a_enable;
        c2[sadc_pkg::B_HALF]      = r.half;
        c2[sadc_pkg::B_SAMPLES_PER_IRQ+:4]   = r.cfg.samples_per_irq;
        c2[sadc_pkg::B_SPLIT_BUFFER_MODE]      = r.cfg.split_buffer_mode;
        c2[sadc_pkg::B_ALTERNATE_MUX_SELECT]      = r.cfg.alternate_mux_select;
        c3[sadc_pkg::B_AUTO_SAMPLE_CLOCKS+:5]   = r.cfg.auto_sample_clocks;
        c3[sadc_pkg::B_RC_CLOCK_SELECT]      = r.cfg.rc_clock_select;
        c3[sadc_pkg::B_CONV_CLOCK_DIVIDER+:6]   = r.cfg.conv_clock_divider;
        ins[sadc_pkg::B_CHA+:4]   = r.cfg.mux_a_channel;
        ins[sadc_pkg::B_CHB+:4]   = r.cfg.mux_b_channel;

        // Registered ack: one wait state, and unmapped addresses read zero.
        if (req) begin
            n.ack = 1'b1;
            n.dat = '0;
            if (adr_i[7:6] == sadc_pkg::RES_PAGE) begin
                n.dat = res_rd;
            end else if (adr_i == sadc_pkg::OFF_CTRL1) begin
                n.dat = c1;
                if (we_i) begin
                    v = merge16(c1, dat_i[15:0], sel_i[1:0]);
                    n.cfg.converter_on       = v[sadc_pkg::B_ON];
                    n.cfg.output_format_sel  = v[sadc_pkg::B_OUTPUT_FORMAT_SEL+:2];
                    n.cfg.trigger_source_sel = v[sadc_pkg::B_TRIGGER_SOURCE_SEL+:3];
                    n.cfg.auto_sample_enable = v[sadc_pkg::B_AUTO_SAMPLE_ENABLE];
                    n.cfg.sample_hold_cmd    = v[sadc_pkg::B_SAMPLE_HOLD_CMD];
                end
            end else if (adr_i == sadc_pkg::OFF_CTRL2) begin
                n.dat = c2;
                if (we_i) begin
                    v = merge16(c2, dat_i[15:0], sel_i[1:0]);
                    n.cfg.scan_mux_a_enable    = v[sadc_pkg::B_SCAN_MUX_A_ENABLE];
                    n.cfg.samples_per_irq      = v[sadc_pkg::B_SAMPLES_PER_IRQ+:4];
                    n.cfg.split_buffer_mode    = v[sadc_pkg::B_SPLIT_BUFFER_MODE];
                    n.cfg.alternate_mux_select = v[sadc_pkg::B_ALTERNATE_MUX_SELECT];
                end
            end else if (adr_i == sadc_pkg::OFF_CTRL3) begin
                n.dat = c3;
                if (we_i) begin
                    v = merge16(c3, dat_i[15:0], sel_i[1:0]);
                    n.cfg.auto_sample_clocks = v[sadc_pkg::B_AUTO_SAMPLE_CLOCKS+:5];
                    n.cfg.rc_clock_select    = v[sadc_pkg::B_RC_CLOCK_SELECT];
                    n.cfg.conv_clock_divider = v[sadc_pkg::B_CONV_CLOCK_DIVIDER+:6];
                end
            end else if (adr_i == sadc_pkg::OFF_INSEL) begin
                n.dat = ins;
                if (we_i) begin
                    v = merge16(ins, dat_i[15:0], sel_i[1:0]);
                    n.cfg.mux_a_channel = v[sadc_pkg::B_CHA+:4];
                    n.cfg.mux_b_channel = v[sadc_pkg::B_CHB+:4];
                end
            end else if (adr_i == sadc_pkg::OFF_SCAN) begin
                n.dat = r.cfg.scan_select;
                if (we_i) begin
                    n.cfg.scan_select = merge16(r.cfg.scan_select, dat_i[15:0], sel_i[1:0]);
                end
            end else if (adr_i == sadc_pkg::OFF_STAT) begin
                n.dat[sadc_pkg::B_IRQ] = r.cfg.conv_irq_flag;
                if (we_i && sel_i[0] && dat_i[sadc_pkg::B_IRQ]) begin
                    n.cfg.conv_irq_flag = 1'b0;
                end
            end
        end

        // Sequencer runs after the bus so a hardware set beats a software clear.
        if (!n.cfg.converter_on) begin
            n.st        = sadc_pkg::ST_IDLE;
            n.cnt       = '0;
            n.smp_cnt   = '0;
            n.scan_idx  = '0;
            n.alt_phase = 1'b0;
        end else begin
            case (r.st)
                sadc_pkg::ST_IDLE: begin
                    start = n.cfg.sample_hold_cmd;
                end
                sadc_pkg::ST_SAMPLE: begin
                    case (r.cfg.trigger_source_sel)
                        sadc_pkg::TRIG_MANUAL: go = !n.cfg.sample_hold_cmd;
                        sadc_pkg::TRIG_AUTO:   go = tick && (r.cnt + 5'h01 >=
                                                   r.cfg.auto_sample_clocks);
                        sadc_pkg::TRIG_EXT:    go = ext_edge;
                        sadc_pkg::TRIG_TIMER:  go = timer_trig_i;
                        default:               go = 1'b0;
                    endcase
                    if (go) begin
                        n.st                  = sadc_pkg::ST_CONV;
                        n.cnt                 = '0;
                        n.cfg.sample_hold_cmd = 1'b0;
                    end else if (tick) begin
                        n.cnt = r.cnt + 5'h01;
                    end
                end
                sadc_pkg::ST_CONV: begin
                    if (tick && r.cnt == sadc_pkg::CONV_LAST) begin
                        n.wr.en   = 1'b1;
                        n.wr.addr = r.cfg.split_buffer_mode ?
                                    {r.half, r.smp_cnt[2:0]} : r.smp_cnt;
                        // Stored right-justified; missing pins read zero.
                        n.wr.data = (r.ch >= sadc_pkg::NUM_PINS) ? 12'h000
                                                                 : sar_data_i;
                        if (r.smp_cnt == r.cfg.samples_per_irq) begin
                            n.smp_cnt           = '0;
                            n.cfg.done          = 1'b1;
                            n.cfg.conv_irq_flag = 1'b1;
                            n.scan_idx          = '0;
                            n.half = r.cfg.split_buffer_mode ? ~r.half : 1'b0;
                        end else begin
                            n.smp_cnt = r.smp_cnt + 4'h1;
                        end
                        if (r.cfg.auto_sample_enable) begin
                            n.cfg.sample_hold_cmd = 1'b1;
                            start                 = 1'b1;
                        end else begin
                            n.st = sadc_pkg::ST_IDLE;
                        end
                    end else if (tick) begin
                        n.cnt = r.cnt + 5'h01;
                    end
                end
                default: begin
                    n.st = sadc_pkg::ST_IDLE;
                end
            endcase
        end

        // Inputs are chosen once per acquisition; a re-arm that ends a group keeps done set.
        if (start) begin
            n.st       = sadc_pkg::ST_SAMPLE;
            n.cnt      = '0;
            n.cfg.done = n.wr.en && r.smp_cnt == r.cfg.samples_per_irq;
            if (r.cfg.alternate_mux_select && r.alt_phase) begin
                n.ch = r.cfg.mux_b_channel;
            end else if (r.cfg.scan_mux_a_enable && r.cfg.scan_select != 16'h0000) begin
                pick       = scan_pick(r.cfg.scan_select, n.scan_idx,
                                       r.cfg.mux_a_channel);
                n.ch       = pick;
                n.scan_idx = {1'b0, pick} + 5'h01;
            end else begin
                n.ch = r.cfg.mux_a_channel;
            end
            n.alt_phase = r.cfg.alternate_mux_select & ~r.alt_phase;
        end

        n.sampling   = (n.st == sadc_pkg::ST_SAMPLE);
        n.converting = (n.st == sadc_pkg::ST_CONV);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r     <= '0;
            r.cfg <= sadc_pkg::CFG_RST;
            r.st  <= sadc_pkg::ST_IDLE;
        end else begin
            r <= n;
        end
    end

    assign dat_o     = {16'h0000, r.dat};
    assign ack_o     = r.ack;
    assign sample_o  = r.sampling;
    assign channel_o = r.ch;
    assign convert_o = r.converting;
    assign done_o    = r.cfg.done;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    logic [4:0] h_ticks;
    always_ff @(posedge clk_i) begin
        if (rst_i || r.st != sadc_pkg::ST_CONV) begin
            h_ticks <= '0;
        end else if (tick) begin
            h_ticks <= h_ticks + 5'h01;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_once;
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");

    property p_fourteen;
        r.wr.en |-> $past(h_ticks) == 5'd13 && $past(tick);
    endproperty
    a_fourteen: assert property (p_fourteen) else $error("conversion not 14 periods");

    property p_abort;
        !n.cfg.converter_on |-> !n.wr.en ##1 r.st == sadc_pkg::ST_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("conversion continued while off");

    property p_zero_pin;
        r.wr.en && $past(r.ch) >= sadc_pkg::NUM_PINS |-> r.wr.data == 12'h000;
    endproperty
    a_zero_pin: assert property (p_zero_pin) else $error("missing pin gave nonzero");

    property p_irq_count;
        $rose(r.cfg.conv_irq_flag) |-> r.wr.en && $past(r.smp_cnt) == r.cfg.samples_per_irq;
    endproperty
    a_irq_count: assert property (p_irq_count) else $error("flag at wrong sample count");

    property p_done_clear;
        $fell(r.cfg.done) |-> r.sampling;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done cleared outside start");

    property p_manual;
        r.st == sadc_pkg::ST_SAMPLE && r.cfg.trigger_source_sel == sadc_pkg::TRIG_MANUAL
            && !n.cfg.sample_hold_cmd && n.cfg.converter_on |=> r.converting;
    endproperty
    a_manual: assert property (p_manual) else $error("manual trigger ignored");

    property p_mux_a;
        $rose(r.sampling) && !r.cfg.alternate_mux_select && !r.cfg.scan_mux_a_enable
            |-> r.ch == r.cfg.mux_a_channel;
    endproperty
    a_mux_a: assert property (p_mux_a) else $error("sample not from group A");

    property p_split;
        r.wr.en && r.cfg.split_buffer_mode |-> r.wr.addr[3] == $past(r.half);
    endproperty
    a_split: assert property (p_split) else $error("write into wrong half");

    c_irq:   cover property ($rose(r.cfg.conv_irq_flag));
    c_abort: cover property (r.converting ##1 !r.cfg.converter_on);
    c_half:  cover property (r.wr.en && r.wr.addr[3]);
    c_auto:  cover property (r.wr.en && r.cfg.trigger_source_sel == sadc_pkg::TRIG_AUTO);
endmodule // sadc_top

// *** tb/sadc_analog_model.sv ***
// Behavioural sample-and-hold in front of the converter.
`timescale 1ns/1ps
module sadc_analog_model (
    input  wire logic       clk_i,
    input  wire logic       sample_i,
    input  wire logic [3:0] channel_i,
    output logic [11:0]     level_o
);
    logic [3:0] held;
    // The level encodes the input held at the end of acquisition, so a wrong input shows.
    always_ff @(posedge clk_i) begin
        if (sample_i) begin
            held <= channel_i;
        end
    end
    assign level_o = {held, 8'h5A};
endmodule // sadc_analog_model

// *** tb/tb_sadc_top.sv ***
// Register-level bench of the converter sequencer.
`timescale 1ns/1ps
module tb_sadc_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic        ack_o, sample_o, convert_o, done_o;
    logic [3:0]  channel_o;
    logic [11:0] sar_data_i;
    logic        timer_trig_i = 1'b0;
    logic [15:0] fmt [4] = '{16'h0B5A, 16'hFB5A, 16'hB5A0, 16'hB5A0};
    logic [3:0]  scn [4] = '{4'h1, 4'h5, 4'h7, 4'h8};
    int          failures = 0;
    int          total_checks = 0;
    int          nconv = 0;
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (convert_o === 1'b1) nconv++;
    end
    sadc_top u_sadc_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'h3),
        .dat_i, .dat_o, .ack_o, .rc_clk_i(1'b0), .ext_trig_i(1'b0), .timer_trig_i,
        .sar_data_i, .sample_o, .channel_o, .convert_o, .done_o);
    sadc_analog_model u_sadc_analog_model (.clk_i, .sample_i(sample_o),
        .channel_i(channel_o), .level_o(sar_data_i));
    task automatic close_out();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic w = 1'b1);
        int n;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {16'h0000, d};
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n == 20) begin
            failures++;
            close_out();
        end
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input string n);
        wr(a, 16'h0000, 1'b0);
        chk(n, e, q[15:0]);
    endtask
    task automatic wait_done();
        int n;
        for (n = 0; n < 400 && done_o !== 1'b1; n++) @(posedge clk_i);
        if (n == 400) begin
            failures++;
            close_out();
        end
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(8'h00, 16'h0000, "ctrl1 reset");
        rd(8'h2C, 16'h0000, "unmapped");
        wr(8'h08, 16'h0000);
        wr(8'h0C, 16'h000B);
        wr(8'h00, 16'h8002);
        chk("sample", 16'h0001, {15'h0000, sample_o});
        chk("channel", 16'h000B, {12'h000, channel_o});
        nconv = 0;
        wr(8'h00, 16'h8000);
        wait_done();
        chk("convert time", 16'h000E, nconv[15:0]);
        rd(8'h14, 16'h0001, "irq flag");
        rd(8'h00, 16'h8001, "done");
        foreach (fmt[i]) begin
            wr(8'h00, {6'h20, i[1:0], 8'h00});
            rd(8'h40, fmt[i], "format");
        end
        wr(8'h40, 16'hFFFF);
        rd(8'h40, 16'hB5A0, "store write");
        wr(8'h14, 16'h0001);
        rd(8'h14, 16'h0000, "flag clear");
        wr(8'h0C, 16'h0006);
        wr(8'h00, 16'h8002);
        wr(8'h00, 16'h8000);
        wr(8'h00, 16'h0000);
        chk("abort", 16'h0000, {15'h0000, convert_o});
        repeat (20) @(posedge clk_i);
        rd(8'h40, 16'h0B5A, "abort keep");
        wr(8'h0C, 16'h000E);
        wr(8'h00, 16'h8002);
        wr(8'h00, 16'h8000);
        wait_done();
        rd(8'h40, 16'h0000, "no pin");
        wr(8'h00, 16'h0000);
        wr(8'h14, 16'h0001);
        wr(8'h04, 16'h040E);
        wr(8'h08, 16'h0100);
        wr(8'h10, 16'h11A2);
        wr(8'h00, 16'h80E6);
        wait_done();
        wr(8'h00, 16'h0000);
        rd(8'h14, 16'h0001, "scan flag");
        rd(8'h04, 16'h048E, "half");
        foreach (scn[i]) begin
            rd(8'h40 + 8'(4 * i), {4'h0, scn[i], 8'h5A}, "scan");
        end
        wr(8'h04, 16'h0000);
        wr(8'h00, 16'h8042);
        repeat (20) @(posedge clk_i);
        chk("timer wait", 16'h0001, {15'h0000, sample_o});
        timer_trig_i <= 1'b1;
        @(posedge clk_i);
        timer_trig_i <= 1'b0;
        wait_done();
        close_out();
    end
endmodule // tb_sadc_top
